/* rtl/lss_defs.vh */
// Constants of the low-side switch serial control block
`ifndef LSS_DEFS_VH
`define LSS_DEFS_VH
`define LSS_SHIFT_W 8
`define LSS_HP_CH 6
`define LSS_CMD_RST 8'h00
`define LSS_FAULT_RST 8'h00
`define LSS_OL_LOW_BIT 6
`define LSS_OL_HIGH_BIT 7
`endif

/* rtl/lss_spi_ctrl.v */
// Serial and parallel control logic of the low-side switch
`timescale 1ns/1ps
`include "lss_defs.vh"
module lss_spi_ctrl #(
	parameter SHIFT_W = `LSS_SHIFT_W
) (
	input wire clk_sys_i,
	input wire reset_i,
	input wire clk_en_i,
	input wire cs_n_i,
	input wire sclk_i,
	input wire si_i,
	input wire mode_i,
	input wire [7:0] parallel_channel_inputs_i,
	input wire limp_pair_input_ch01_i,
	input wire limp_pair_input_ch23_i,
	input wire limp_pair_input_ch45_i,
	input wire [7:0] fault_raw_i,
	output reg so_o,
	output reg so_oe_n_o,
	output reg [7:0] switch_outputs_o,
	output reg [5:0] on_open_load_enable_o
);
	// Pin bit positions and reset levels
	localparam PIN_W = 23;
	localparam [PIN_W-1:0] PIN_RST = 23'h400000;
	localparam PIN_CS = 22;
	localparam PIN_SCLK = 21;
	localparam PIN_SI = 20;
	localparam PIN_MODE = 19;
	localparam PIN_PAR = 11;
	localparam PIN_LIMP = 8;
	localparam PIN_FAULT = 0;

	// Transfer states
	localparam [2:0] ST_IDLE = 3'h1;
	localparam [2:0] ST_SHIFT = 3'h2;
	localparam [2:0] ST_LOAD = 3'h4;

	// Synchronised pins
	wire [PIN_W-1:0] pin_raw;
	wire [PIN_W-1:0] pin_sync;
	wire cs_n;
	wire sclk;
	wire si;
	wire mode;
	wire [7:0] par_sync;
	wire [2:0] limp_sync;
	wire [7:0] fault_sync;

	// Link edges
	reg cs_d_reg;
	reg sclk_d_reg;
	wire cs_fall;
	wire cs_rise;
	wire sclk_rise;
	wire sclk_fall;

	// Transfer control
	reg [2:0] state_reg;
	reg [2:0] state_next;
	wire in_shift;
	wire in_load;
	reg [SHIFT_W-1:0] shift_reg;
	reg [7:0] cmd_reg;
	reg read_reg;

	// Fault status
	reg [7:0] fault_reg;
	reg [7:0] snap_reg;
	wire clear_ok;
	wire fault_open;
	wire [7:0] fault_keep;
	wire [7:0] fault_next;

	// Channel selection
	wire [5:0] hp_cmd;
	wire [5:0] hp_par;
	wire [5:0] hp_serial;
	wire [5:0] hp_limp;
	wire [5:0] hp_next;
	wire [1:0] lp_next;
	wire ol_any;
	wire [5:0] ol_next;
	genvar g;

	// Pin inputs gathered for the synchronisers
	assign pin_raw = {cs_n_i, sclk_i, si_i, mode_i, parallel_channel_inputs_i, limp_pair_input_ch45_i,
		limp_pair_input_ch23_i, limp_pair_input_ch01_i, fault_raw_i};

	// Two flip-flops per pin bit
	generate
		for (g = 0; g < PIN_W; g = g + 1) begin : g_sync
			reg meta_reg;
			reg sync_reg;
			always @(posedge clk_sys_i) begin
				if (reset_i) begin
					meta_reg <= PIN_RST[g];
					sync_reg <= PIN_RST[g];
				end else if (clk_en_i) begin
					meta_reg <= pin_raw[g];
					sync_reg <= meta_reg;
				end
			end
			assign pin_sync[g] = sync_reg;
		end
	endgenerate

	assign cs_n = pin_sync[PIN_CS];
	assign sclk = pin_sync[PIN_SCLK];
	assign si = pin_sync[PIN_SI];
	assign mode = pin_sync[PIN_MODE];
	assign par_sync = pin_sync[PIN_PAR+7:PIN_PAR];
	assign limp_sync = pin_sync[PIN_LIMP+2:PIN_LIMP];
	assign fault_sync = pin_sync[PIN_FAULT+7:PIN_FAULT];

	// Edge detection, idle levels after reset
	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			cs_d_reg <= 1'b1;
			sclk_d_reg <= 1'b0;
		end else if (clk_en_i) begin
			cs_d_reg <= cs_n;
			sclk_d_reg <= sclk;
		end
	end

	assign cs_fall = cs_d_reg & ~cs_n;
	assign cs_rise = ~cs_d_reg & cs_n;
	assign sclk_rise = ~sclk_d_reg & sclk & ~cs_n;
	assign sclk_fall = sclk_d_reg & ~sclk & ~cs_n;

	// Transfer state register
	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			state_reg <= ST_IDLE;
		end else if (clk_en_i) begin
			state_reg <= state_next;
		end
	end

	// Idle, selected, then one cycle of command load
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_IDLE: begin
				if (cs_fall) begin
					state_next = ST_SHIFT;
				end
			end
			ST_SHIFT: begin
				if (cs_rise) begin
					state_next = ST_LOAD;
				end
			end
			ST_LOAD: begin
				if (cs_fall) begin
					state_next = ST_SHIFT;
				end else begin
					state_next = ST_IDLE;
				end
			end
			default: begin
				state_next = ST_IDLE;
			end
		endcase
	end

	assign in_shift = (state_reg == ST_SHIFT);
	assign in_load = (state_reg == ST_LOAD);

	// Shift register and fault snapshot
	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			shift_reg <= {SHIFT_W{1'b0}};
			snap_reg <= `LSS_FAULT_RST;
		end else if (clk_en_i) begin
			if (cs_fall) begin
				shift_reg <= fault_reg;
				snap_reg <= fault_reg;
			end else if (sclk_rise) begin
				shift_reg <= {shift_reg[SHIFT_W-2:0], si};
			end
		end
	end

	// Serial data output
	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			so_o <= 1'b0;
		end else if (clk_en_i) begin
			if (cs_fall) begin
				so_o <= fault_reg[7];
			end else if (sclk_fall) begin
				so_o <= shift_reg[SHIFT_W-1];
			end
		end
	end

	// Output enable, low while selected outside limp mode
	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			so_oe_n_o <= 1'b1;
		end else if (clk_en_i) begin
			so_oe_n_o <= cs_n | mode;
		end
	end

	// Status counts as read once a bit has been shifted out
	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			read_reg <= 1'b0;
		end else if (clk_en_i) begin
			if (cs_fall) begin
				read_reg <= 1'b0;
			end else if (sclk_fall) begin
				read_reg <= 1'b1;
			end
		end
	end

	// Command latch, last byte before deselect
	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			cmd_reg <= `LSS_CMD_RST;
		end else if (clk_en_i) begin
			if (in_load) begin
				cmd_reg <= shift_reg[7:0];
			end
		end
	end

	// Fault register, frozen while selected
	assign clear_ok = in_load & read_reg;
	assign fault_open = ~in_shift & ~cs_fall;

	// New faults win over the clear
	generate
		for (g = 0; g < 8; g = g + 1) begin : g_fault
			assign fault_keep[g] = clear_ok ? (fault_reg[g] & ~snap_reg[g]) : fault_reg[g];
			assign fault_next[g] = fault_keep[g] | fault_sync[g];
		end
	endgenerate

	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			fault_reg <= `LSS_FAULT_RST;
		end else if (clk_en_i) begin
			if (fault_open) begin
				fault_reg <= fault_next;
			end
		end
	end

	// High-power channel selection
	generate
		for (g = 0; g < `LSS_HP_CH; g = g + 1) begin : g_hp
			assign hp_cmd[g] = cmd_reg[g];
			assign hp_par[g] = par_sync[g];
			assign hp_serial[g] = hp_cmd[g] | hp_par[g];
			assign hp_limp[g] = limp_sync[g / 2];
			assign hp_next[g] = mode ? hp_limp[g] : hp_serial[g];
		end
	endgenerate

	// Low-power channels
	assign lp_next = mode ? 2'h0 : par_sync[7:6];

	// Open-load enables
	assign ol_any = cmd_reg[`LSS_OL_LOW_BIT] | cmd_reg[`LSS_OL_HIGH_BIT];

	generate
		for (g = 0; g < `LSS_HP_CH; g = g + 1) begin : g_ol
			assign ol_next[g] = ol_any;
		end
	endgenerate

	// Registered channel outputs
	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			switch_outputs_o <= 8'h00;
		end else if (clk_en_i) begin
			switch_outputs_o <= {lp_next, hp_next};
		end
	end

	// Registered open-load enables
	always @(posedge clk_sys_i) begin
		if (reset_i) begin
			on_open_load_enable_o <= 6'h00;
		end else if (clk_en_i) begin
			on_open_load_enable_o <= ol_next;
		end
	end

endmodule // lss_spi_ctrl

/* testbench/lss_spi_ctrl_monitor.sv */
// Port checker of the switch control
`timescale 1ns/1ps
module lss_spi_ctrl_monitor (input wire clk_sys_i, input wire reset_i, input wire cs_n_i, input wire mode_i,
	input wire [7:0] parallel_channel_inputs_i, input wire limp_pair_input_ch01_i, input wire so_oe_n_o,
	input wire [7:0] switch_outputs_o);
	wire [7:0] p = parallel_channel_inputs_i;
	wire [7:0] s = switch_outputs_o;
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (reset_i);
	property p_mso; mode_i[*8] |-> so_oe_n_o; endproperty
	a_mso: assert property (p_mso) else $error("so in mode");
	property p_cso; cs_n_i[*8] |-> so_oe_n_o; endproperty
	a_cso: assert property (p_cso) else $error("so idle");
	property p_rso; $rose(cs_n_i) |-> ##[1:8] so_oe_n_o; endproperty
	a_rso: assert property (p_rso) else $error("so held");
	property p_mlp; mode_i[*8] |-> s[7:6] == 2'b00; endproperty
	a_mlp: assert property (p_mlp) else $error("low on");
	property p_lmp; (mode_i && limp_pair_input_ch01_i)[*8] |-> s[1:0] == 2'b11; endproperty
	a_lmp: assert property (p_lmp) else $error("pair off");
	property p_par; (!mode_i && p[0])[*8] |-> s[0]; endproperty
	a_par: assert property (p_par) else $error("pin off");
	property p_lp1; (!mode_i && p[6])[*8] |-> s[6]; endproperty
	a_lp1: assert property (p_lp1) else $error("low off");
	property p_lp0; (!mode_i && !p[7])[*8] |-> !s[7]; endproperty
	a_lp0: assert property (p_lp0) else $error("low on");
endmodule // lss_spi_ctrl_monitor
bind lss_spi_ctrl lss_spi_ctrl_monitor u_mon (.clk_sys_i, .reset_i, .cs_n_i, .mode_i, .parallel_channel_inputs_i,
	.limp_pair_input_ch01_i, .so_oe_n_o, .switch_outputs_o);

/* testbench/lss_master_model.sv */
// Serial master model
`timescale 1ns/1ps
module lss_master_model (output logic cs_n_o = 1'b1, output logic sclk_o = 1'b0, output logic si_o = 1'b0,
	input wire so_i);
	task automatic xfer(input int n, input logic [31:0] d, output logic [31:0] r);
		r = 32'h0;
		cs_n_o = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			si_o = d[i];
			#62.5 sclk_o = 1'b1;
			r = {r[30:0], so_i};
			#62.5 sclk_o = 1'b0;
		end
		si_o = 1'b0;
		#125 cs_n_o = 1'b1;
		#250;
	endtask
endmodule // lss_master_model

/* testbench/testbench.sv */
// Bench of the switch control
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin fail_count++; $display("unexpected %0t %h %h", $time, a, b); end end
module testbench;
	logic clk_sys_i = 1'b0, reset_i = 1'b1, clk_en_i = 1'b1, mode_i = 1'b0, cs_n_i, sclk_i, si_i, so_o, so_oe_n_o;
	logic limp_pair_input_ch01_i = 1'b1, limp_pair_input_ch23_i = 1'b0, limp_pair_input_ch45_i = 1'b1;
	logic [7:0] parallel_channel_inputs_i = 8'h43, fault_raw_i = 8'h81, switch_outputs_o;
	logic [5:0] on_open_load_enable_o;
	logic [31:0] r;
	int fail_count = 0, check_count = 0;
	always #4 clk_sys_i = ~clk_sys_i;
	lss_master_model u_master (.cs_n_o(cs_n_i), .sclk_o(sclk_i), .si_o(si_i), .so_i(so_oe_n_o ? 1'b1 : so_o));
	lss_spi_ctrl u_dut (.*);
	task conclude;
		$display("checks %0d fails %0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task x(input int n, input logic [31:0] d, input logic [31:0] e);
		u_master.xfer(n, d, r);
		`CHK(r, e)
	endtask
	initial begin
		repeat (4) @(negedge clk_sys_i);
		reset_i = 1'b0;
		repeat (8) @(negedge clk_sys_i);
		`CHK(switch_outputs_o, 8'h43)
		fault_raw_i = 8'h00;
		x(16, 32'h3ca5, 32'h813c);
		`CHK(switch_outputs_o, 8'h67)
		`CHK(on_open_load_enable_o, 6'h3f)
		x(8, 32'h25, 32'h00);
		$display("test serial done");
		@(negedge clk_sys_i) mode_i = 1'b1;
		x(8, 32'h12, 32'hff);
		`CHK(switch_outputs_o, 8'h33)
		@(negedge clk_sys_i) mode_i = 1'b0;
		parallel_channel_inputs_i = 8'h00;
		repeat (8) @(negedge clk_sys_i);
		`CHK(switch_outputs_o, 8'h12)
		$display("test mode done");
		x(32, 32'h12345678, 32'h00123456);
		`CHK(switch_outputs_o, 8'h38)
		$display("test chain done");
		@(negedge clk_sys_i) clk_en_i = 1'b0;
		parallel_channel_inputs_i = 8'h01;
		repeat (3) @(negedge clk_sys_i);
		`CHK(switch_outputs_o, 8'h38)
		clk_en_i = 1'b1;
		repeat (8) @(negedge clk_sys_i);
		`CHK(switch_outputs_o, 8'h39)
		$display("test enable done");
		conclude;
	end
endmodule // testbench
